// File: core/mcg_top.v
// Five 16-bit counters with source selection, hardware gating and command decoding
`timescale 1ns/1ps
`include "mcg_defines.vh"
// Notes on behaviour
// - polarity bit picks rising or falling edge
// - four-bit field picks one of 16 sources
// - lower neighbour terminal count chains counters
// - gating 000 counts whenever armed
// - 100 own gate high, 101 low
// - 010/011 use upper/lower neighbour gate pin
// - 110/111 start on gate edge, run cycle
// - with repeat, new edge restarts cycle
// - 001 gates on lower terminal count pulse
// - control port byte captured in command register
// - mask bits pick counters acted on together
// - counter number 1 to 5 selects one
// - top bits pick arm, load, save, disarm
// - group 000/110 never loads the pointer
// - toggle set, toggle clear and step
// - master mode bit set and clear commands
// - prefetch enable, disable and master reset
// - arm enables counting, zero bit unchanged
// - disarm during terminal count waits until leaving
// - arm restarts alternation from hold register
// - terminal count reloads from load or hold
// - retrigger saves count, reloads on next edge
module mcg_top
#(
   parameter NCNT = 5,
   parameter CW   = 16
)
(
   input  wire             ref_clk_i,
   input  wire             reset_i,
   input  wire [7:0]       cmd_data_i,
   input  wire             cmd_wr_i,
   input  wire [4:0]       count_input_pin_i,
   input  wire [4:0]       own_gate_pin_i,
   input  wire [4:0]       source_polarity_bit_i,
   input  wire [19:0]      source_select_i,
   input  wire [14:0]      gating_field_i,
   input  wire [4:0]       retrigger_bit_i,
   input  wire [4:0]       repeat_i,
   input  wire [4:0]       alt_reload_i,
   input  wire [4:0]       count_up_i,
   input  wire [NCNT*CW-1:0] load_value_i,
   output wire [NCNT*CW-1:0] count_o,
   output wire [NCNT*CW-1:0] hold_o,
   output wire [4:0]       terminal_count_o,
   output wire [4:0]       toggle_o,
   output wire [4:0]       armed_o,
   output reg  [1:0]       element_o,
   output reg  [2:0]       group_o,
   output reg              byte_pointer_o,
   output reg              pointer_sequencing_disable_bit_o,
   output reg              freq_out_gate_bit_o,
   output reg              bus_width_bit_o,
   output reg              write_prefetch_o,
   output reg              frequency_output_o
);
   // ==========================================
   // Command register
   reg  [7:0] command_byte;
   reg        cmd_valid;

   always @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         command_byte <= 8'h00;
         cmd_valid <= 1'b0;
      end
      else
      begin
         cmd_valid <= cmd_wr_i;
         if (cmd_wr_i)
            command_byte <= cmd_data_i;
      end
   end

   wire [4:0] arm_m;
   wire [4:0] load_m;
   wire [4:0] dis_m;
   wire [4:0] save_m;
   wire [4:0] step_m;
   wire [4:0] tset_m;
   wire [4:0] tclr_m;
   wire       ptr_load;
   wire       seq_dis;
   wire       seq_en;
   wire       frequency_output_off;
   wire       frequency_output_on;
   wire       bus16;
   wire       bus8;
   wire       pf_en;
   wire       pf_dis;
   wire       mreset;

   mcg_cmd_decode u_dec
   (
      .cmd_i      (command_byte),
      .valid_i    (cmd_valid),
      .arm_o      (arm_m),
      .load_o     (load_m),
      .disarm_o   (dis_m),
      .save_o     (save_m),
      .step_o     (step_m),
      .tset_o     (tset_m),
      .tclr_o     (tclr_m),
      .ptr_load_o (ptr_load),
      .seq_dis_o  (seq_dis),
      .seq_en_o   (seq_en),
      .frequency_output_off_o (frequency_output_off),
      .frequency_output_on_o  (frequency_output_on),
      .bus16_o    (bus16),
      .bus8_o     (bus8),
      .pf_en_o    (pf_en),
      .pf_dis_o   (pf_dis),
      .mreset_o   (mreset)
   );

   // ==========================================
   // Master mode bits and data pointer
   reg [`MCG_PRE_W-1:0] prescale;
   wire [4:0]           freq_tap;
   assign freq_tap = {prescale[`MCG_FTAP4], prescale[`MCG_FTAP3], prescale[`MCG_FTAP2],
                      prescale[`MCG_FTAP1], prescale[`MCG_FTAP0]};

   always @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prescale <= {`MCG_PRE_W{1'b0}};
         element_o <= 2'h0;
         group_o <= 3'h0;
         byte_pointer_o <= 1'b0;
         pointer_sequencing_disable_bit_o <= 1'b0;
         freq_out_gate_bit_o <= 1'b0;
         bus_width_bit_o <= 1'b0;
         write_prefetch_o <= 1'b0;
         frequency_output_o <= 1'b0;
      end
      else if (mreset)
      begin
         prescale <= {`MCG_PRE_W{1'b0}};
         element_o <= 2'h0;
         group_o <= 3'h0;
         byte_pointer_o <= 1'b0;
         pointer_sequencing_disable_bit_o <= 1'b0;
         freq_out_gate_bit_o <= 1'b0;
         bus_width_bit_o <= 1'b0;
         write_prefetch_o <= 1'b0;
         frequency_output_o <= 1'b0;
      end
      else
      begin
         prescale <= prescale + 1'b1;
         frequency_output_o <= freq_tap[0] & ~freq_out_gate_bit_o;
         if (ptr_load)
         begin
            element_o <= command_byte[4:3];
            group_o <= command_byte[2:0];
            byte_pointer_o <= 1'b1;
         end
         if (seq_dis)
            pointer_sequencing_disable_bit_o <= 1'b1;
         if (seq_en)
            pointer_sequencing_disable_bit_o <= 1'b0;
         if (frequency_output_off)
            freq_out_gate_bit_o <= 1'b1;
         if (frequency_output_on)
            freq_out_gate_bit_o <= 1'b0;
         if (bus16)
            bus_width_bit_o <= 1'b1;
         if (bus8)
            bus_width_bit_o <= 1'b0;
         if (pf_en)
            write_prefetch_o <= 1'b1;
         if (pf_dis)
            write_prefetch_o <= 1'b0;
      end
   end

   // ==========================================
   // Counter channels
   wire [4:0] tc_w;
   genvar i;
   generate
      for (i = 0; i < NCNT; i = i + 1)
      begin : g_cnt
         localparam integer UPN = (i + 1) % NCNT;
         localparam integer LON = (i + NCNT - 1) % NCNT;
         wire          src_lvl;
         reg           src_q;
         reg           gate_lvl;
         reg           gate_q;
         reg  [CW-1:0] cnt;
         reg  [CW-1:0] hold;
         reg           armed;
         reg           tc;
         reg           tog;
         reg           run;
         reg           alt_sel;
         reg           dis_pend;
         reg           rt_pend;
         wire [2:0]    gm;
         wire [CW-1:0] ld_val;
         wire [CW-1:0] reload;
         wire [CW-1:0] cnt_next;
         wire          edge_mode;
         wire          gate_ok;
         wire          gate_edge;
         wire          qual;
         wire          at_term;
         wire          evt;
         wire          rt_fire;
         wire          rt_edge;
         wire          leave_tc;
         wire          last;

         mcg_src_sel u_src
         (
            .ref_clk_i   (ref_clk_i),
            .reset_i     (reset_i),
            .sel_i       (source_select_i[4*i +: 4]),
            .pol_i       (source_polarity_bit_i[i]),
            .tc_lower_i  (tc_w[LON]),
            .src_pins_i  (count_input_pin_i),
            .gate_pins_i (own_gate_pin_i),
            .freq_i      (freq_tap),
            .src_o       (src_lvl)
         );

         assign gm = gating_field_i[3*i +: 3];
         assign ld_val = load_value_i[CW*i +: CW];

         always @*
         begin
            case (gm)
               `MCG_GT_TCLO: gate_lvl = tc_w[LON];
               `MCG_GT_GUP:  gate_lvl = own_gate_pin_i[UPN];
               `MCG_GT_GLO:  gate_lvl = own_gate_pin_i[LON];
               `MCG_GT_HI:   gate_lvl = own_gate_pin_i[i];
               `MCG_GT_LOW:  gate_lvl = ~own_gate_pin_i[i];
               `MCG_GT_EHI:  gate_lvl = own_gate_pin_i[i];
               `MCG_GT_ELO:  gate_lvl = ~own_gate_pin_i[i];
               default:      gate_lvl = 1'b1;
            endcase
         end

         assign edge_mode = (gm == `MCG_GT_EHI) | (gm == `MCG_GT_ELO);
         assign gate_ok = (gm == `MCG_GT_NONE) ? 1'b1 : (edge_mode ? run : gate_lvl);
         assign gate_edge = gate_lvl & ~gate_q;
         // A counter in terminal count always takes the next edge so it cannot stick there
         assign qual = src_lvl & ~src_q & ((armed & gate_ok) | tc);
         assign at_term = count_up_i[i] ? (cnt == `MCG_TERM_UP) : (cnt == `MCG_TERM_DN);
         assign evt = qual | step_m[i] | (load_m[i] & at_term & ~tc);
         assign rt_edge = (gm != `MCG_GT_NONE) & retrigger_bit_i[i] & gate_edge;
         assign rt_fire = rt_pend & (qual | step_m[i] | load_m[i]);
         assign reload = (alt_reload_i[i] & ~alt_sel) ? hold : ld_val;
         assign cnt_next = count_up_i[i] ? cnt + 1'b1 : cnt - 1'b1;
         assign leave_tc = tc & ~rt_fire & ((evt & ~at_term) | (load_m[i] & ~evt));
         assign last = ~alt_reload_i[i] | alt_sel;

         always @(posedge ref_clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               src_q <= 1'b0;
               // Starting high keeps a gate already active at release from faking an edge
               gate_q <= 1'b1;
               cnt <= `MCG_CNT_RST;
               hold <= `MCG_CNT_RST;
               armed <= 1'b0;
               tc <= 1'b0;
               tog <= 1'b0;
               run <= 1'b0;
               alt_sel <= 1'b0;
               dis_pend <= 1'b0;
               rt_pend <= 1'b0;
            end
            else if (mreset)
            begin
               src_q <= src_lvl;
               gate_q <= gate_lvl;
               cnt <= `MCG_CNT_RST;
               hold <= `MCG_CNT_RST;
               armed <= 1'b0;
               tc <= 1'b0;
               tog <= 1'b0;
               run <= 1'b0;
               alt_sel <= 1'b0;
               dis_pend <= 1'b0;
               rt_pend <= 1'b0;
            end
            else
            begin
               src_q <= src_lvl;
               gate_q <= gate_lvl;
               if (save_m[i] | rt_edge)
                  hold <= cnt;
               if (rt_fire)
               begin
                  cnt <= ld_val;
                  rt_pend <= 1'b0;
               end
               else if (evt)
               begin
                  if (at_term)
                  begin
                     cnt <= reload;
                     tc <= 1'b1;
                     alt_sel <= ~alt_sel;
                     if (tc)
                        tog <= ~tog;
                     if (last)
                     begin
                        if (~repeat_i[i])
                           armed <= 1'b0;
                        if (edge_mode)
                           run <= 1'b0;
                     end
                  end
                  else
                     cnt <= cnt_next;
               end
               else if (load_m[i])
                  cnt <= reload;
               if (leave_tc)
               begin
                  tc <= 1'b0;
                  tog <= ~tog;
                  if (dis_pend)
                  begin
                     armed <= 1'b0;
                     dis_pend <= 1'b0;
                  end
               end
               if (rt_edge)
                  rt_pend <= 1'b1;
               // Edge arriving as the cycle ends restarts it rather than being lost
               if (edge_mode & gate_edge & armed)
                  run <= 1'b1;
               if (dis_m[i])
               begin
                  if (tc & ~leave_tc)
                     dis_pend <= 1'b1;
                  else
                     armed <= 1'b0;
               end
               if (arm_m[i])
               begin
                  armed <= 1'b1;
                  dis_pend <= 1'b0;
                  alt_sel <= 1'b0;
               end
               if (tset_m[i])
                  tog <= 1'b1;
               if (tclr_m[i])
                  tog <= 1'b0;
            end
         end

         assign tc_w[i] = tc;
         assign count_o[CW*i +: CW] = cnt;
         assign hold_o[CW*i +: CW] = hold;
         assign terminal_count_o[i] = tc;
         assign toggle_o[i] = tog;
         assign armed_o[i] = armed;
      end
   endgenerate
endmodule

// File: core/mcg_defines.vh
// Constants for the five-channel counter controller and its command decoder
`ifndef MCG_DEFINES_VH
`define MCG_DEFINES_VH
// ==========================================
// Command register
`define MCG_CMD_W        8
`define MCG_OP_PTR       3'h0
`define MCG_OP_ARM       3'h1
`define MCG_OP_LOAD      3'h2
`define MCG_OP_LDARM     3'h3
`define MCG_OP_DISSAVE   3'h4
`define MCG_OP_SAVE      3'h5
`define MCG_OP_DISARM    3'h6
`define MCG_OP_EXT       3'h7
`define MCG_SUB_CLR      2'h0
`define MCG_SUB_SET      2'h1
`define MCG_SUB_STEP     2'h2
`define MCG_SUB_MISC     2'h3
`define MCG_LO_SEQ       3'h0
`define MCG_LO_FREQUENCY_OUTPUT      3'h6
`define MCG_LO_BUS       3'h7
`define MCG_LO_PF_EN     3'h0
`define MCG_LO_PF_DIS    3'h1
`define MCG_LO_MRST      3'h7
`define MCG_GRP_BAD0     3'h0
`define MCG_GRP_BAD1     3'h6
// ==========================================
// Gating field codes
`define MCG_GT_NONE      3'h0
`define MCG_GT_TCLO      3'h1
`define MCG_GT_GUP       3'h2
`define MCG_GT_GLO       3'h3
`define MCG_GT_HI        3'h4
`define MCG_GT_LOW       3'h5
`define MCG_GT_EHI       3'h6
`define MCG_GT_ELO       3'h7
// ==========================================
// Counters, sources and reset values
`define MCG_NUM_SRC      16
`define MCG_CNT_RST      16'h0000
`define MCG_TERM_DN      16'h0001
`define MCG_TERM_UP      16'hFFFF
`define MCG_PRE_W        16
`define MCG_FTAP0        0
`define MCG_FTAP1        3
`define MCG_FTAP2        6
`define MCG_FTAP3        9
`define MCG_FTAP4        12
`endif

// File: core/mcg_src_sel.v
// Count source selector with edge polarity for one counter
`timescale 1ns/1ps
`include "mcg_defines.vh"
module mcg_src_sel
(
   input  wire       ref_clk_i,
   input  wire       reset_i,
   input  wire [3:0] sel_i,
   input  wire       pol_i,
   input  wire       tc_lower_i,
   input  wire [4:0] src_pins_i,
   input  wire [4:0] gate_pins_i,
   input  wire [4:0] freq_i,
   output reg        src_o
);
   // ==========================================
   // Selection
   // Order: lower terminal count, source pins, gate pins, internal taps
   wire [`MCG_NUM_SRC-1:0] cand;
   assign cand = {freq_i, gate_pins_i, src_pins_i, tc_lower_i};

   // Inverting the level makes a falling edge look like a rising one downstream
   always @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         src_o <= 1'b0;
      else
         src_o <= cand[sel_i] ^ pol_i;
   end
endmodule

// File: core/mcg_cmd_decode.v
// Command byte decoder producing per-counter and master-mode strobes
`timescale 1ns/1ps
`include "mcg_defines.vh"
module mcg_cmd_decode
(
   input  wire [7:0] cmd_i,
   input  wire       valid_i,
   output reg  [4:0] arm_o,
   output reg  [4:0] load_o,
   output reg  [4:0] disarm_o,
   output reg  [4:0] save_o,
   output reg  [4:0] step_o,
   output reg  [4:0] tset_o,
   output reg  [4:0] tclr_o,
   output reg        ptr_load_o,
   output reg        seq_dis_o,
   output reg        seq_en_o,
   output reg        frequency_output_off_o,
   output reg        frequency_output_on_o,
   output reg        bus16_o,
   output reg        bus8_o,
   output reg        pf_en_o,
   output reg        pf_dis_o,
   output reg        mreset_o
);
   // ==========================================
   // Counter number to one-hot; 000, 110 and 111 select nothing
   function [4:0] num_hot;
      input [2:0] n;
      begin
         case (n)
            3'h1:    num_hot = 5'h01;
            3'h2:    num_hot = 5'h02;
            3'h3:    num_hot = 5'h04;
            3'h4:    num_hot = 5'h08;
            3'h5:    num_hot = 5'h10;
            default: num_hot = 5'h00;
         endcase
      end
   endfunction

   // ==========================================
   // Decode
   wire [2:0] op;
   wire [1:0] sub;
   wire [2:0] lo;
   wire [4:0] mask;
   assign op   = cmd_i[7:5];
   assign sub  = cmd_i[4:3];
   assign lo   = cmd_i[2:0];
   assign mask = valid_i ? cmd_i[4:0] : 5'h00;

   always @*
   begin
      arm_o = 5'h00;
      load_o = 5'h00;
      disarm_o = 5'h00;
      save_o = 5'h00;
      step_o = 5'h00;
      tset_o = 5'h00;
      tclr_o = 5'h00;
      ptr_load_o = 1'b0;
      seq_dis_o = 1'b0;
      seq_en_o = 1'b0;
      frequency_output_off_o = 1'b0;
      frequency_output_on_o = 1'b0;
      bus16_o = 1'b0;
      bus8_o = 1'b0;
      pf_en_o = 1'b0;
      pf_dis_o = 1'b0;
      mreset_o = 1'b0;
      // Codes outside the table fall through with every strobe low
      case (op)
         `MCG_OP_PTR:
            ptr_load_o = valid_i & (lo != `MCG_GRP_BAD0) & (lo != `MCG_GRP_BAD1);
         `MCG_OP_ARM:     arm_o = mask;
         `MCG_OP_LOAD:    load_o = mask;
         `MCG_OP_LDARM:
         begin
            load_o = mask;
            arm_o = mask;
         end
         `MCG_OP_DISSAVE:
         begin
            disarm_o = mask;
            save_o = mask;
         end
         `MCG_OP_SAVE:    save_o = mask;
         `MCG_OP_DISARM:  disarm_o = mask;
         `MCG_OP_EXT:
         begin
            case (sub)
               `MCG_SUB_SET:
               begin
                  tset_o = valid_i ? num_hot(lo) : 5'h00;
                  seq_dis_o = valid_i & (lo == `MCG_LO_SEQ);
                  frequency_output_off_o = valid_i & (lo == `MCG_LO_FREQUENCY_OUTPUT);
                  bus16_o = valid_i & (lo == `MCG_LO_BUS);
               end
               `MCG_SUB_CLR:
               begin
                  tclr_o = valid_i ? num_hot(lo) : 5'h00;
                  seq_en_o = valid_i & (lo == `MCG_LO_SEQ);
                  frequency_output_on_o = valid_i & (lo == `MCG_LO_FREQUENCY_OUTPUT);
                  bus8_o = valid_i & (lo == `MCG_LO_BUS);
               end
               `MCG_SUB_STEP:   step_o = valid_i ? num_hot(lo) : 5'h00;
               `MCG_SUB_MISC:
               begin
                  pf_en_o = valid_i & (lo == `MCG_LO_PF_EN);
                  pf_dis_o = valid_i & (lo == `MCG_LO_PF_DIS);
                  mreset_o = valid_i & (lo == `MCG_LO_MRST);
               end
               default:   step_o = 5'h00;
            endcase
         end
         default:   arm_o = 5'h00;
      endcase
   end
endmodule

// File: test/mcg_host.sv
// Host model that writes command bytes to the control port
`timescale 1ns/1ps
module mcg_host
(
   input  wire       ref_clk_i,
   output reg        cmd_wr_o,
   output reg  [7:0] cmd_data_o
);
   initial
   begin
      cmd_wr_o = 1'b0;
      cmd_data_o = 8'h00;
   end
   // ==========================================
   // One whole byte per strobe; callers only pass defined codes
   task send(input [7:0] b);
      begin
         cmd_data_o = b;
         cmd_wr_o = 1'b1;
         @(negedge ref_clk_i);
         cmd_wr_o = 1'b0;
         // Idle bus shows the inverse so a stale byte never looks valid
         cmd_data_o = ~b;
      end
   endtask
endmodule

// File: test/mcg_top_asserts.sv
// Assertions on the command port of the counter controller
`timescale 1ns/1ps
`include "mcg_defines.vh"
module mcg_top_asserts
(
   input wire       ref_clk_i,
   input wire       reset_i,
   input wire [7:0] cmd_data_i,
   input wire       cmd_wr_i,
   input wire [4:0] terminal_count_o,
   input wire [4:0] armed_o,
   input wire [4:0] toggle_o,
   input wire [1:0] element_o,
   input wire [2:0] group_o,
   input wire       byte_pointer_o,
   input wire       pointer_sequencing_disable_bit_o,
   input wire       freq_out_gate_bit_o,
   input wire       bus_width_bit_o,
   input wire       write_prefetch_o,
   input wire       frequency_output_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // ==========================================
   // Command steps
   sequence s_cmd(logic [7:0] c);
      cmd_wr_i && cmd_data_i == c;
   endsequence
   sequence s_op(logic [2:0] op);
      cmd_wr_i && cmd_data_i[7:5] == op;
   endsequence
   property p_arm;
      s_op(`MCG_OP_ARM) |-> ##2
         (armed_o & $past(cmd_data_i[4:0], 2)) == $past(cmd_data_i[4:0], 2);
   endproperty
   a_arm: assert property (p_arm) else $error("arm mask not applied");
   // Only checked outside terminal count, where disarm is not deferred
   property p_dis;
      s_op(`MCG_OP_DISARM) ##1 terminal_count_o == 5'h00 |-> ##1
         (armed_o & $past(cmd_data_i[4:0], 2)) == 5'h00;
   endproperty
   a_dis: assert property (p_dis) else $error("disarm mask not applied");
   property p_ptr;
      s_op(`MCG_OP_PTR) ##0 (cmd_data_i[2:0] != 3'h0 && cmd_data_i[2:0] != 3'h6) |-> ##2
         {element_o, group_o, byte_pointer_o} == {$past(cmd_data_i[4:0], 2), 1'b1};
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load wrong");
   property p_tset;
      s_op(3'h7) ##0 (cmd_data_i[4:3] == 2'h1 && cmd_data_i[2:0] inside {[1:5]}) |-> ##2
         toggle_o[$past(cmd_data_i[2:0], 2) - 3'h1];
   endproperty
   a_tset: assert property (p_tset) else $error("toggle not set");
   property p_seq;
      s_cmd(8'hE8) |-> ##2 pointer_sequencing_disable_bit_o;
   endproperty
   a_seq: assert property (p_seq) else $error("sequencing bit not set");
   property p_bus;
      s_cmd(8'hE7) |-> ##2 !bus_width_bit_o;
   endproperty
   a_bus: assert property (p_bus) else $error("bus width bit not cleared");
   property p_fgate;
      freq_out_gate_bit_o [*3] |-> !frequency_output_o;
   endproperty
   a_fgate: assert property (p_fgate) else $error("frequency output not gated");
   property p_pf;
      s_cmd(8'hF8) |-> ##2 write_prefetch_o;
   endproperty
   a_pf: assert property (p_pf) else $error("prefetch not enabled");
   property p_mrst;
      s_cmd(8'hFF) |-> ##2 armed_o == 5'h00 && toggle_o == 5'h00 && !write_prefetch_o;
   endproperty
   a_mrst: assert property (p_mrst) else $error("master reset incomplete");
endmodule
bind mcg_top mcg_top_asserts i_chk (.*);

// File: test/tb_mcg_top.sv
// Self-checking bench for the counter controller command port
`timescale 1ns/1ps
module tb_mcg_top;
   localparam [63:0] MM_CMD = 64'hE8E0EEE6EFE7F8F9;
   localparam [31:0] MM_EXP = 32'h80402010;
   reg          ref_clk;
   reg          reset;
   wire [7:0]   cmd_data;
   wire         cmd_wr;
   reg  [4:0]   pin;
   reg  [4:0]   gate;
   reg  [4:0]   pol;
   reg  [14:0]  gating;
   reg  [79:0]  load;
   wire [79:0]  count;
   wire [79:0]  hold;
   wire [4:0]   toggle;
   wire [4:0]   armed;
   wire [4:0]   tcnt;
   wire         frequency_output;
   wire [5:0]   ptr;
   wire [3:0]   mm;
   integer      err_count;
   integer      checked;
   integer      cyc;
   integer      i;
   mcg_host i_host (.ref_clk_i(ref_clk), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data));
   mcg_top i_dut
   (
      .ref_clk_i                        (ref_clk),
      .reset_i                          (reset),
      .cmd_data_i                       (cmd_data),
      .cmd_wr_i                         (cmd_wr),
      .count_input_pin_i                (pin),
      .own_gate_pin_i                   (gate),
      .source_polarity_bit_i            (pol),
      .source_select_i                  (20'h00001),
      .gating_field_i                   (gating),
      .retrigger_bit_i                  (5'h00),
      .repeat_i                         (5'h1F),
      .alt_reload_i                     (5'h00),
      .count_up_i                       (5'h00),
      .load_value_i                     (load),
      .count_o                          (count),
      .hold_o                           (hold),
      .terminal_count_o                 (tcnt),
      .toggle_o                         (toggle),
      .armed_o                          (armed),
      .element_o                        (ptr[5:4]),
      .group_o                          (ptr[3:1]),
      .byte_pointer_o                   (ptr[0]),
      .pointer_sequencing_disable_bit_o (mm[3]),
      .freq_out_gate_bit_o              (mm[2]),
      .bus_width_bit_o                  (mm[1]),
      .write_prefetch_o                 (mm[0]),
      .frequency_output_o               (frequency_output)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task chk(input [79:0] got, input [79:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
         end
      end
   endtask
   // Effect lands on the edge after the strobe edge
   task cmd(input [7:0] b);
      begin
         i_host.send(b);
         repeat (2) @(negedge ref_clk);
      end
   endtask
   // Pin level held long enough for sync plus edge detect
   task src(input v);
      begin
         pin[0] = v;
         repeat (4) @(negedge ref_clk);
      end
   endtask
   task summarize;
      begin
         $display("checked %0d err_count %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // ==========================================
   // Hang guard, far above the roughly 140 cycles the tests need
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         err_count = err_count + 1;
         summarize;
      end
   end
   // ==========================================
   // Tests
   initial
   begin
      err_count = 0;
      checked = 0;
      cyc = 0;
      reset = 1'b1;
      pin = 5'h00;
      gate = 5'h00;
      pol = 5'h00;
      gating = 15'h0004;
      load = 80'h5;
      repeat (12) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      chk(armed, 5'h00);
      chk(mm, 4'h0);
      $display("test reset done");
      cmd(8'h41);
      chk(count[15:0], 16'h0005);
      cmd(8'h21);
      chk(armed, 5'h01);
      cmd(8'h36);
      chk(armed, 5'h17);
      cmd(8'hD2);
      chk(armed, 5'h05);
      $display("test masks done");
      src(1'b1);
      src(1'b0);
      chk(count[15:0], 16'h0005);
      gate[0] = 1'b1;
      src(1'b1);
      src(1'b0);
      chk(count[15:0], 16'h0004);
      cmd(8'hF1);
      chk(count[15:0], 16'h0003);
      cmd(8'hA1);
      chk(hold[15:0], 16'h0003);
      // Flip polarity while gated off so the level change is not counted
      gate[0] = 1'b0;
      pol[0] = 1'b1;
      repeat (3) @(negedge ref_clk);
      gate[0] = 1'b1;
      src(1'b1);
      chk(count[15:0], 16'h0003);
      src(1'b0);
      chk(count[15:0], 16'h0002);
      gating = 15'h0005;
      src(1'b1);
      src(1'b0);
      chk(count[15:0], 16'h0002);
      gate[0] = 1'b0;
      src(1'b1);
      src(1'b0);
      chk(count[15:0], 16'h0001);
      $display("test counting done");
      cmd(8'hEB);
      chk(toggle, 5'h04);
      cmd(8'hE3);
      chk(toggle, 5'h00);
      cmd(8'h62);
      chk(armed, 5'h07);
      src(1'b1);
      src(1'b0);
      chk(tcnt, 5'h01);
      chk(count[31:0], 32'hFFFF0005);
      cmd(8'h81);
      chk(armed, 5'h07);
      chk(hold[15:0], 16'h0005);
      src(1'b1);
      src(1'b0);
      chk(armed, 5'h06);
      chk(count[15:0], 16'h0004);
      $display("test terminal count done");
      cmd(8'h0B);
      chk(ptr, 6'h17);
      cmd(8'h17);
      chk(ptr, 6'h2F);
      for (i = 0; i < 8; i = i + 1)
      begin
         cmd(MM_CMD[63 - 8 * i -: 8]);
         chk(mm, MM_EXP[31 - 4 * i -: 4]);
         chk(frequency_output & mm[2], 1'b0);
      end
      $display("test commands done");
      cmd(8'hF8);
      cmd(8'hFF);
      chk(armed, 5'h00);
      chk(count, 80'h0);
      chk(mm, 4'h0);
      $display("test master reset done");
      summarize;
   end
endmodule
